// File: design/spc_pkg.sv
// spc_pkg: constants and carrier types of the serial configuration port.
// assumes: shared by the port top, its checker and the bench; pure definitions.
`default_nettype none

package spc_pkg;

  // header and address space
  localparam int unsigned HDR_BITS  = 16;
  localparam int unsigned BYTE_BITS = 8;
  localparam int unsigned NUM_REGS  = 100;
  localparam logic [14:0] ADDR_TOP  = 15'h0063;

  // register addresses
  localparam logic [6:0] ADDR_CFG       = 7'h00;
  localparam logic [6:0] ADDR_STREAM    = 7'h01;
  localparam logic [6:0] ADDR_POWER     = 7'h02;
  localparam logic [6:0] ADDR_TYPE      = 7'h03;
  localparam logic [6:0] ADDR_ID_LO     = 7'h04;
  localparam logic [6:0] ADDR_ID_HI     = 7'h05;
  localparam logic [6:0] ADDR_REV       = 7'h06;
  localparam logic [6:0] ADDR_MAKER_LO  = 7'h0C;
  localparam logic [6:0] ADDR_MAKER_HI  = 7'h0D;
  localparam logic [6:0] ADDR_COMMIT    = 7'h0F;
  localparam logic [6:0] ADDR_LEVELS    = 7'h1F;
  localparam logic [6:0] SOFT_RESET_LOW = 7'h02;

  // field positions
  localparam int unsigned CFG_SRESET_BIT = 7;
  localparam int unsigned CFG_LBF_BIT    = 6;
  localparam int unsigned CFG_ASC_BIT    = 5;
  localparam int unsigned CFG_FOURW_BIT  = 4;
  localparam int unsigned STREAM_OFF_BIT = 7;
  localparam int unsigned RB_SEL_BIT     = 5;
  localparam int unsigned EDGE_SEL_BIT   = 0;
  localparam int unsigned COMMIT_BIT     = 0;

  // writable bits per plain register
  localparam logic [7:0] STREAM_WMASK = 8'hA1;
  localparam logic [7:0] POWER_WMASK  = 8'h07;
  localparam logic [7:0] LEVELS_WMASK = 8'h07;
  localparam logic [7:0] FULL_WMASK   = 8'hFF;

  // reset value of every stored byte and config bit
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic       BIT_RST  = 1'b0;

  // reserved addresses inside 0x00..0x63, one bit per address
  localparam logic [NUM_REGS-1:0] RESV_MASK = 100'h7FE14A70C8C88888000004F80;

  // shadowed wide divider bytes
  localparam int unsigned NUM_DIV = 14;
  localparam logic [NUM_DIV-1:0][6:0] DIV_ADDR = {
    7'h47, 7'h46, 7'h45, 7'h44, 7'h1B, 7'h1A, 7'h17,
    7'h16, 7'h15, 7'h14, 7'h13, 7'h12, 7'h11, 7'h10};

  // timing: reset pin pulse and system clock
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned RESET_PULSE_NS = 100;
  localparam int unsigned RESET_PULSE_CYC =
    (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // configuration seen by the rest of the device
  typedef struct packed {
    logic       four_wire;
    logic       low_bit_first;
    logic       ascend;
    logic       stream_off;
    logic       readback_source_select;
    logic       read_edge_select;
    logic       serial_out_level_sel;
    logic       irq_lockv_level_sel;
    logic       lockf_level_sel;
    logic [2:0] power_bits;
  } spc_cfg_t;

  typedef logic [NUM_DIV-1:0][7:0] spc_div_t;

endpackage : spc_pkg

`default_nettype wire

// File: design/spc_sync3.sv
// spc_sync3: three-flop level synchroniser with agreement filter.
// assumes: input is a slow level from another clock domain.
`default_nettype none

module spc_sync3 (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic resetn_i,
  // level in and out
  input  wire logic level_i,
  output logic      level_o
);

  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic out;
  } spc_sync_state_t;

  spc_sync_state_t st_q;
  spc_sync_state_t st_d;

  // change passes once the second and third flop agree
  always_comb begin
    st_d     = st_q;
    st_d.ff1 = level_i;
    st_d.ff2 = st_q.ff1;
    st_d.ff3 = st_q.ff2;
    if (st_q.ff2 == st_q.ff3) begin
      st_d.out = st_q.ff3;
    end
  end

  // state register
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_o = st_q.out;

endmodule : spc_sync3

`default_nettype wire

// File: design/spc_port.sv
// spc_port: serial configuration port with byte streaming, mirrored
// bits and shadowed wide dividers.
// assumes: serial_clk_i runs only while chip_select_n_i is low; the
// pad logic resolves sdio/sdo from the output enables.
`default_nettype none

module spc_port #(
  // identity values, arbitrary
  parameter logic [7:0]  PART_TYPE = 8'h5A,
  parameter logic [15:0] PART_ID   = 16'h1234,
  parameter logic [7:0]  PART_REV  = 8'h01,
  parameter logic [15:0] MAKER_ID  = 16'hA5C3
) (
  // system clock and reset pin
  input  wire logic         clock_i,
  input  wire logic         resetn_i,
  // serial link
  input  wire logic         serial_clk_i,
  input  wire logic         chip_select_n_i,
  input  wire logic         sdio_i,
  output logic              sdio_o,
  output logic              sdio_oe_o,
  output logic              sdo_o,
  output logic              sdo_oe_o,
  // configuration towards the device
  output spc_pkg::spc_cfg_t cfg_o,
  output spc_pkg::spc_div_t div_work_o
);

  // register storage and config bits, reset by the pin only
  typedef struct packed {
    logic [spc_pkg::NUM_REGS-1:0][7:0] mem;
    spc_pkg::spc_div_t                 work;
    logic                              low_bit_first;
    logic                              ascend;
    logic                              four_wire;
    logic                              commit_tgl;
  } spc_cfg_state_t;

  // transfer engine, cleared whenever chip select is high
  typedef struct packed {
    logic [4:0]  cnt;
    logic        in_data;
    logic        is_read;
    logic [15:0] sh;
    logic [14:0] addr;
    logic [7:0]  tx;
    logic [2:0]  tx_idx;
    logic        oe3;
    logic        oe4;
    logic        out_r;
  } spc_eng_state_t;

  // system clock side: committed dividers
  typedef struct packed {
    logic              seen_tgl;
    spc_pkg::spc_div_t div;
  } spc_sys_state_t;

  spc_cfg_state_t cfg_q;
  spc_cfg_state_t cfg_d;
  spc_eng_state_t eng_q;
  spc_eng_state_t eng_d;
  spc_sys_state_t sys_q;
  spc_sys_state_t sys_d;
  logic           out_f_q;
  logic           eng_rst_n;
  logic           tgl_sync;
  logic           cur_bit;
  logic           edge_sel;

  // engine is held in reset outside a frame, so outputs let go at once
  assign eng_rst_n = resetn_i & ~chip_select_n_i;
  assign edge_sel  = cfg_q.mem[spc_pkg::ADDR_STREAM][spc_pkg::EDGE_SEL_BIT];

  // bit presented for the current tx position
  assign cur_bit = cfg_q.low_bit_first ? eng_q.tx[eng_q.tx_idx]
                                       : eng_q.tx[3'h7 - eng_q.tx_idx];

  // next address in a stream, wrapping inside the implemented range
  function automatic logic [14:0] step_addr(input logic [14:0] a);
    logic [14:0] n;
    n = a;
    if (cfg_q.mem[spc_pkg::ADDR_STREAM][spc_pkg::STREAM_OFF_BIT]) begin
      n = a;
    end else if (cfg_q.ascend) begin
      n = (a >= spc_pkg::ADDR_TOP) ? 15'h0000 : a + 15'h0001;
    end else begin
      n = (a == 15'h0000) ? spc_pkg::ADDR_TOP : a - 15'h0001;
    end
    return n;
  endfunction : step_addr

  // divider slot of an address, NUM_DIV when not a divider byte
  function automatic logic [4:0] div_slot(input logic [6:0] a);
    logic [4:0] s;
    s = 5'(spc_pkg::NUM_DIV);
    for (int i = 0; i < spc_pkg::NUM_DIV; i++) begin
      if (spc_pkg::DIV_ADDR[i] == a) begin
        s = 5'(i);
      end
    end
    return s;
  endfunction : div_slot

  // writable bits of a plain stored register
  function automatic logic [7:0] wr_mask(input logic [6:0] a);
    logic [7:0] m;
    m = spc_pkg::FULL_WMASK;
    if (spc_pkg::RESV_MASK[a]) begin
      m = 8'h00;
    end else begin
      case (a)
        spc_pkg::ADDR_CFG, spc_pkg::ADDR_COMMIT,
        spc_pkg::ADDR_TYPE, spc_pkg::ADDR_ID_LO,
        spc_pkg::ADDR_ID_HI, spc_pkg::ADDR_REV,
        spc_pkg::ADDR_MAKER_LO, spc_pkg::ADDR_MAKER_HI: m = 8'h00;
        spc_pkg::ADDR_STREAM: m = spc_pkg::STREAM_WMASK;
        spc_pkg::ADDR_POWER:  m = spc_pkg::POWER_WMASK;
        spc_pkg::ADDR_LEVELS: m = spc_pkg::LEVELS_WMASK;
        default:              m = spc_pkg::FULL_WMASK;
      endcase
    end
    return m;
  endfunction : wr_mask

  // read data for an address
  function automatic logic [7:0] rd_byte(input logic [14:0] a);
    logic [7:0] r;
    logic [6:0] ix;
    logic [4:0] sl;
    ix = a[6:0];
    sl = div_slot(ix);
    r  = 8'h00;
    if (a <= spc_pkg::ADDR_TOP) begin
      case (ix)
        spc_pkg::ADDR_CFG: begin
          // upper nibble mirrored bit-reversed into lower
          r = {1'b0, cfg_q.low_bit_first, cfg_q.ascend, cfg_q.four_wire,
               cfg_q.four_wire, cfg_q.ascend, cfg_q.low_bit_first, 1'b0};
        end
        spc_pkg::ADDR_TYPE:     r = PART_TYPE;
        spc_pkg::ADDR_ID_LO:    r = PART_ID[7:0];
        spc_pkg::ADDR_ID_HI:    r = PART_ID[15:8];
        spc_pkg::ADDR_REV:      r = PART_REV;
        spc_pkg::ADDR_MAKER_LO: r = MAKER_ID[7:0];
        spc_pkg::ADDR_MAKER_HI: r = MAKER_ID[15:8];
        default: begin
          if (sl != 5'(spc_pkg::NUM_DIV) &&
              cfg_q.mem[spc_pkg::ADDR_STREAM][spc_pkg::RB_SEL_BIT]) begin
            r = cfg_q.work[sl[3:0]];
          end else begin
            r = cfg_q.mem[ix] & wr_mask(ix);
          end
        end
      endcase
    end
    return r;
  endfunction : rd_byte

  // mirrored bit update: both copies one sets, both zero clears
  function automatic logic mirror_bit(input logic old, input logic hi,
                                      input logic lo);
    logic n;
    n = old;
    if (hi && lo) begin
      n = 1'b1;
    end else if (!hi && !lo) begin
      n = 1'b0;
    end
    return n;
  endfunction : mirror_bit

  // serial engine and register writes
  always_comb begin
    logic [15:0] sh_n;
    logic [7:0]  wbyte;
    logic [6:0]  wa;
    logic [7:0]  m;
    logic [4:0]  sl;
    logic        do_wr;
    sh_n  = '0;
    wbyte = '0;
    wa    = '0;
    m     = '0;
    sl    = '0;
    do_wr = 1'b0;
    eng_d = eng_q;
    cfg_d = cfg_q;
    // both orders fill the same frame slots: msb first shifts left,
    // lsb first shifts right, so dir lands in bit 15 either way
    sh_n = cfg_q.low_bit_first ? {sdio_i, eng_q.sh[15:1]}
                               : {eng_q.sh[14:0], sdio_i};
    eng_d.sh = sh_n;
    if (!eng_q.in_data) begin
      eng_d.cnt = eng_q.cnt + 5'h01;
      if (eng_q.cnt == 5'(spc_pkg::HDR_BITS - 1)) begin
        eng_d.in_data = 1'b1;
        eng_d.cnt     = 5'h00;
        eng_d.is_read = sh_n[15];
        eng_d.addr    = sh_n[14:0];
        if (sh_n[15]) begin
          eng_d.tx     = rd_byte(sh_n[14:0]);
          eng_d.tx_idx = 3'h0;
          eng_d.addr   = step_addr(sh_n[14:0]);
          eng_d.oe3    = ~cfg_q.four_wire;
          eng_d.oe4    = cfg_q.four_wire;
        end
      end
    end else begin
      eng_d.cnt = {2'b00, eng_q.cnt[2:0] + 3'h1};
      eng_d.tx_idx = eng_q.tx_idx + 3'h1;
      if (eng_q.cnt[2:0] == 3'(spc_pkg::BYTE_BITS - 1)) begin
        eng_d.addr = step_addr(eng_q.addr);
        if (eng_q.is_read) begin
          eng_d.tx = rd_byte(eng_q.addr);
        end else begin
          do_wr = (eng_q.addr <= spc_pkg::ADDR_TOP);
          wbyte = cfg_q.low_bit_first ? sh_n[15:8] : sh_n[7:0];
        end
      end
    end
    // frame bit for the rising-edge launch, used when edge select is set
    eng_d.out_r = cfg_q.low_bit_first ? eng_d.tx[eng_d.tx_idx]
                                      : eng_d.tx[3'h7 - eng_d.tx_idx];
    if (do_wr) begin
      wa = eng_q.addr[6:0];
      sl = div_slot(wa);
      m  = wr_mask(wa);
      if (wa == spc_pkg::ADDR_CFG) begin
        cfg_d.low_bit_first = mirror_bit(cfg_q.low_bit_first,
          wbyte[spc_pkg::CFG_LBF_BIT], wbyte[7 - spc_pkg::CFG_LBF_BIT]);
        cfg_d.ascend = mirror_bit(cfg_q.ascend,
          wbyte[spc_pkg::CFG_ASC_BIT], wbyte[7 - spc_pkg::CFG_ASC_BIT]);
        cfg_d.four_wire = mirror_bit(cfg_q.four_wire,
          wbyte[spc_pkg::CFG_FOURW_BIT], wbyte[7 - spc_pkg::CFG_FOURW_BIT]);
        // soft reset clears 0x02 up, keeps 0x00/0x01 and the engine
        if (wbyte[spc_pkg::CFG_SRESET_BIT] &&
            wbyte[7 - spc_pkg::CFG_SRESET_BIT]) begin
          for (int i = spc_pkg::SOFT_RESET_LOW; i < spc_pkg::NUM_REGS;
               i++) begin
            cfg_d.mem[i] = spc_pkg::BYTE_RST;
          end
          cfg_d.work       = '0;
          cfg_d.commit_tgl = ~cfg_q.commit_tgl;
        end
      end else if (wa == spc_pkg::ADDR_COMMIT) begin
        // self-clearing commit: shadow becomes the working copy
        if (wbyte[spc_pkg::COMMIT_BIT]) begin
          for (int i = 0; i < spc_pkg::NUM_DIV; i++) begin
            cfg_d.work[i] = cfg_q.mem[spc_pkg::DIV_ADDR[i]];
          end
          cfg_d.commit_tgl = ~cfg_q.commit_tgl;
        end
      end else begin
        // divider bytes land only in the shadow here
        cfg_d.mem[wa] = (cfg_q.mem[wa] & ~m) | (wbyte & m);
      end
      if (sl != 5'(spc_pkg::NUM_DIV)) begin
        cfg_d.mem[wa] = wbyte;
      end
    end
  end

  // config registers: pin reset only, defaults three-wire msb down
  always_ff @(posedge serial_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_q.mem           <= '0;
      cfg_q.work          <= '0;
      cfg_q.low_bit_first <= spc_pkg::BIT_RST;
      cfg_q.ascend        <= spc_pkg::BIT_RST;
      cfg_q.four_wire     <= spc_pkg::BIT_RST;
      cfg_q.commit_tgl    <= spc_pkg::BIT_RST;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // engine registers: cleared by chip select high
  always_ff @(posedge serial_clk_i or negedge eng_rst_n) begin
    if (!eng_rst_n) begin
      eng_q <= '0;
    end else begin
      eng_q <= eng_d;
    end
  end

  // falling-edge launch of read data, the default read edge
  always_ff @(negedge serial_clk_i or negedge eng_rst_n) begin
    if (!eng_rst_n) begin
      out_f_q <= 1'b0;
    end else begin
      out_f_q <= cur_bit;
    end
  end

  // commit toggle crosses; work bytes are stable long before it lands
  spc_sync3 u_commit_sync (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .level_i  (cfg_q.commit_tgl),
    .level_o  (tgl_sync)
  );

  // system side capture of committed dividers
  always_comb begin
    sys_d = sys_q;
    if (tgl_sync != sys_q.seen_tgl) begin
      sys_d.seen_tgl = tgl_sync;
      sys_d.div      = cfg_q.work;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sys_q <= '0;
    end else begin
      sys_q <= sys_d;
    end
  end

  // pins: edge select picks the launching flop
  assign sdio_o    = edge_sel ? eng_q.out_r : out_f_q;
  assign sdo_o     = edge_sel ? eng_q.out_r : out_f_q;
  assign sdio_oe_o = eng_q.oe3;
  assign sdo_oe_o  = eng_q.oe4;

  // configuration outputs
  assign cfg_o.four_wire     = cfg_q.four_wire;
  assign cfg_o.low_bit_first = cfg_q.low_bit_first;
  assign cfg_o.ascend        = cfg_q.ascend;
  assign cfg_o.stream_off    =
    cfg_q.mem[spc_pkg::ADDR_STREAM][spc_pkg::STREAM_OFF_BIT];
  assign cfg_o.readback_source_select =
    cfg_q.mem[spc_pkg::ADDR_STREAM][spc_pkg::RB_SEL_BIT];
  assign cfg_o.read_edge_select     = edge_sel;
  assign cfg_o.serial_out_level_sel = cfg_q.mem[spc_pkg::ADDR_LEVELS][0];
  assign cfg_o.irq_lockv_level_sel  = cfg_q.mem[spc_pkg::ADDR_LEVELS][1];
  assign cfg_o.lockf_level_sel      = cfg_q.mem[spc_pkg::ADDR_LEVELS][2];
  assign cfg_o.power_bits = cfg_q.mem[spc_pkg::ADDR_POWER][2:0];
  assign div_work_o       = sys_q.div;

endmodule : spc_port

`default_nettype wire

// File: verification/spc_port_asserts.sv
// spc_port_asserts: pin relations of the serial configuration port.
// assumes: bound into spc_port and sees only its ports.
`default_nettype none

module spc_port_asserts (
  // clock and reset
  input wire logic              clock_i,
  input wire logic              resetn_i,
  // serial link
  input wire logic              serial_clk_i,
  input wire logic              chip_select_n_i,
  input wire logic              sdio_oe_o,
  input wire logic              sdo_oe_o,
  // configuration
  input wire spc_pkg::spc_cfg_t cfg_o,
  input wire spc_pkg::spc_div_t div_work_o
);
  logic [5:0] rises_q;
  logic [3:0] idle_q;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);

  // rises in this frame; deselect clears at once, like the engine
  always_ff @(posedge serial_clk_i or posedge chip_select_n_i) begin
    if (chip_select_n_i) begin
      rises_q <= 6'h00;
    end else if (rises_q != 6'h3F) begin
      rises_q <= rises_q + 6'h01;
    end
  end

  // cycles since deselect; commit settles well before 15
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      idle_q <= 4'h0;
    end else if (!chip_select_n_i) begin
      idle_q <= 4'h0;
    end else if (idle_q != 4'hF) begin
      idle_q <= idle_q + 4'h1;
    end
  end

  sequence s_cs_idle;
    chip_select_n_i [*2];
  endsequence
  sequence s_reset_left;
    $rose(resetn_i);
  endsequence

  a_cs_release: assert property (
    s_cs_idle |-> !sdio_oe_o && !sdo_oe_o)
    else $error("data pin driven while deselected");
  a_sdo_quiet_3w: assert property (
    !cfg_o.four_wire |-> !sdo_oe_o)
    else $error("sdo driven in three-wire mode");
  a_sdio_quiet_4w: assert property (
    cfg_o.four_wire |-> !sdio_oe_o)
    else $error("sdio driven in four-wire mode");
  a_oe_after_hdr: assert property (
    (sdio_oe_o || sdo_oe_o) |-> rises_q >= 6'h10)
    else $error("output enabled before the header ended");
  a_oe_stands: assert property (
    ($fell(sdio_oe_o) || $fell(sdo_oe_o)) |-> chip_select_n_i)
    else $error("output dropped inside a frame");
  a_cfg_quiet: assert property (
    chip_select_n_i && $past(chip_select_n_i) |-> $stable(cfg_o))
    else $error("config changed with no transfer");
  a_div_quiet: assert property (
    idle_q == 4'hF |-> $stable(div_work_o))
    else $error("working divider changed without commit");
  a_reset_dflt: assert property (
    s_reset_left |-> cfg_o == '0 && div_work_o == '0 && !sdo_oe_o)
    else $error("defaults wrong after reset");
endmodule : spc_port_asserts

bind spc_port spc_port_asserts u_chk (
  .clock_i        (clock_i),
  .resetn_i       (resetn_i),
  .serial_clk_i   (serial_clk_i),
  .chip_select_n_i(chip_select_n_i),
  .sdio_oe_o      (sdio_oe_o),
  .sdo_oe_o       (sdo_oe_o),
  .cfg_o          (cfg_o),
  .div_work_o     (div_work_o)
);

`default_nettype wire

// File: verification/spc_master_model.sv
// spc_master_model: serial master framing reads and writes, either order.
// assumes: the bench resolves the shared data line into miso_i.
`default_nettype none

module spc_master_model #(
  parameter int HALF_NS = 32
) (
  // serial link towards the port
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // bit order of the frames; only the bench flips it, between frames
  logic lsb_first = 1'b0;

  // idle: clock parked low, frame closed
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // one frame of nb whole bytes; data right-aligned, first byte highest
  task automatic xfer(input logic rd, input logic [14:0] addr,
                      input int nb, input logic [23:0] wd,
                      output logic [23:0] q);
    logic [15:0] hdr;
    int          nbits;
    int          idx;
    hdr    = {rd, addr};            // direction flag on top; leads msb-first frames only
    nbits  = 16 + 8 * nb;
    q      = 24'h000000;
    cs_n_o = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      // lsb first reverses the header and each data byte
      idx = nbits - 1 - i;
      if (lsb_first && i >= 16) begin
        idx = idx - 7 + 2 * ((i - 16) % 8);
      end
      // bit changes while clock is low; read phase toggles a let-go line
      mosi_o = (i < 16) ? hdr[lsb_first ? i : 15 - i] :
               (rd ? ~mosi_o : wd[idx]);
      #(HALF_NS);
      // sampled late in the low phase, settled for either launch edge
      if (rd && i >= 16) begin
        q[idx] = miso_i;   // keeps clocking for more bytes
      end
      sclk_o = 1'b1;
      #(HALF_NS);
      sclk_o = 1'b0;
    end
    #(HALF_NS);
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;                // never parked at the last value
    #(HALF_NS);
  endtask : xfer
endmodule : spc_master_model

`default_nettype wire

// File: verification/tb_top.sv
// tb_top: self-checking bench for the serial configuration port.
// assumes: package, port, checker and master model compiled first.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0]  T_TYPE = 8'h3C;   // arbitrary identity value
  localparam logic [15:0] T_ID   = 16'h6B2D; // arbitrary identity value

  logic              clock_i;
  logic              resetn_i;
  wire logic         serial_clk_i;
  wire logic         chip_select_n_i;
  wire logic         mosi;
  wire logic         sdio_i;
  wire logic         miso;
  logic              sdio_o;
  logic              sdio_oe_o;
  logic              sdo_o;
  logic              sdo_oe_o;
  spc_pkg::spc_cfg_t cfg_o;
  spc_pkg::spc_div_t div_work_o;
  int                failures = 0;
  int                tests_run = 0;
  int                cycles = 0;

  // shared line: the port wins while it drives, else the master
  assign sdio_i = sdio_oe_o ? sdio_o : mosi;
  assign miso   = sdo_oe_o ? sdo_o : sdio_i;

  spc_port #(.PART_TYPE(T_TYPE), .PART_ID(T_ID), .PART_REV(8'h2E),
             .MAKER_ID(16'h4417)) uut (
    .clock_i(clock_i), .resetn_i(resetn_i), .serial_clk_i(serial_clk_i),
    .chip_select_n_i(chip_select_n_i), .sdio_i(sdio_i), .sdio_o(sdio_o),
    .sdio_oe_o(sdio_oe_o), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
    .cfg_o(cfg_o), .div_work_o(div_work_o));

  spc_master_model u_master (
    .sclk_o(serial_clk_i), .cs_n_o(chip_select_n_i), .mosi_o(mosi),
    .miso_i(miso));

  // system clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // hang guard, about three times the expected run
  always @(posedge clock_i) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      $display("BAD timeout expected done seen hang");
      results();
    end
  end

  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  task automatic check(input string what, input logic [23:0] exp,
                       input logic [23:0] got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // pin reset held for the documented minimum width
  task automatic pulse_reset;
    @(posedge clock_i);
    #1 resetn_i = 1'b0;
    repeat (spc_pkg::RESET_PULSE_CYC) @(posedge clock_i);
    #1 resetn_i = 1'b1;
  endtask : pulse_reset

  // debug addresses are never written here
  task automatic wr(input logic [14:0] a, input int nb, input logic [23:0] d);
    logic [23:0] unused;
    @(posedge clock_i);
    #1 u_master.xfer(1'b0, a, nb, d, unused);
  endtask : wr

  task automatic rd(input logic [14:0] a, input int nb,
                    output logic [23:0] q);
    @(posedge clock_i);
    #1 u_master.xfer(1'b1, a, nb, 24'h000000, q);
  endtask : rd

  task automatic t_defaults;
    logic [23:0] q;
    check("cfg", 24'h000000, 24'(cfg_o));
    rd(15'h0004, 2, q);
    check("ids", {8'h00, T_ID[7:0], T_TYPE}, q);
    wr(15'h0004, 2, 24'h00FFFF);
    rd(15'h0004, 2, q);
    check("read-only ids", {8'h00, T_ID[7:0], T_TYPE}, q);
    $display("end of defaults");
  endtask : t_defaults

  task automatic t_mirror;
    logic [23:0] q;
    wr(15'h0000, 1, 24'h000020);
    rd(15'h0000, 1, q);
    check("half mirror", 24'h000000, q);
    check("ascend held", 24'h000000, 24'(cfg_o.ascend));
    wr(15'h0000, 1, 24'h000024);
    rd(15'h0000, 1, q);
    check("full mirror", 24'h000024, q);
    check("ascend set", 24'h000001, 24'(cfg_o.ascend));
    $display("end of mirror");
  endtask : t_mirror

  task automatic t_wrap;
    logic [23:0] q;
    wr(15'h0063, 3, 24'hA52400);
    rd(15'h0063, 2, q);
    check("upward wrap", 24'h00A524, q);
    wr(15'h0000, 1, 24'h000000);
    rd(15'h0000, 2, q);
    check("downward wrap", 24'h0000A5, q);
    $display("end of wrap");
  endtask : t_wrap

  task automatic t_shadow;
    logic [23:0] q;
    wr(15'h0011, 2, 24'h001234);
    repeat (10) @(posedge clock_i);
    check("work early", 24'h000000, 24'(div_work_o[1:0]));
    rd(15'h0011, 1, q);
    check("shadow read", 24'h000012, q);
    wr(15'h000F, 1, 24'h000001); // commit in a later frame
    repeat (10) @(posedge clock_i);
    check("work late", 24'h001234, 24'(div_work_o[1:0]));
    wr(15'h0001, 1, 24'h000020);
    wr(15'h0011, 1, 24'h000055);
    rd(15'h0011, 1, q);
    check("working read", 24'h000012, q);
    wr(15'h0001, 1, 24'h000000);
    $display("end of shadow");
  endtask : t_shadow

  task automatic t_levels;
    logic [23:0] q;
    wr(15'h001F, 1, 24'h0000FD);
    rd(15'h001F, 1, q);
    check("level reg", 24'h000005, q);
    check("level pins", 24'h000005, 24'({cfg_o.lockf_level_sel,
      cfg_o.irq_lockv_level_sel, cfg_o.serial_out_level_sel}));
    wr(15'h0007, 1, 24'h0000FF);
    rd(15'h0007, 1, q);
    check("reserved", 24'h000000, q);
    rd(15'h0070, 1, q);
    check("beyond range", 24'h000000, q);
    $display("end of levels");
  endtask : t_levels

  task automatic t_four;
    logic [23:0] q;
    wr(15'h0000, 1, 24'h000018);
    rd(15'h001F, 1, q);
    check("sdo read", 24'h000005, q);
    check("four wire", 24'h000001, 24'(cfg_o.four_wire));
    wr(15'h0000, 1, 24'h000000);
    rd(15'h0000, 1, q);
    check("three wire", 24'h000000, q);
    check("released", 24'h000000, 24'({sdo_oe_o, sdio_oe_o}));
    $display("end of four wire");
  endtask : t_four

  task automatic t_reset;
    logic [23:0] q;
    wr(15'h0000, 1, 24'h000024);
    pulse_reset();
    check("cfg reset", 24'h000000, 24'(cfg_o));
    check("work reset", 24'h000000, 24'(div_work_o[1:0]));
    rd(15'h001F, 1, q);
    check("levels reset", 24'h000000, q);
    $display("end of reset");
  endtask : t_reset

  // held address, rising read edge, lsb-first frames and soft reset
  task automatic t_modes;
    logic [23:0] q;
    wr(15'h0001, 1, 24'h000081);
    check("held and rise", 24'h000003, 24'({cfg_o.stream_off,
      cfg_o.read_edge_select}));
    rd(15'h0004, 2, q);
    check("rise edge", {8'h00, T_ID[7:0], T_ID[7:0]}, q);
    wr(15'h0001, 1, 24'h000000);
    wr(15'h0000, 1, 24'h000042);
    u_master.lsb_first = 1'b1;
    rd(15'h0004, 1, q);
    check("lsb read", {16'h0000, T_ID[7:0]}, q);
    wr(15'h001F, 1, 24'h000001);
    check("lsb write", 24'h000001, 24'(cfg_o.serial_out_level_sel));
    wr(15'h0000, 1, 24'h000000);
    u_master.lsb_first = 1'b0;
    check("msb again", 24'h000000, 24'(cfg_o.low_bit_first));
    wr(15'h0000, 1, 24'h000081);
    rd(15'h001F, 1, q);
    check("soft reset", 24'h000000, q);
    $display("end of modes");
  endtask : t_modes

  // main sequence
  initial begin
    resetn_i = 1'b0;
    pulse_reset();
    t_defaults();
    t_mirror();
    t_wrap();
    t_shadow();
    t_levels();
    t_four();
    t_reset();
    t_modes();
    results();
  end
endmodule : tb_top

`default_nettype wire
